/* File: core/art_map.svh */
// register addresses, field positions, reset values and timing counts of the auto-reload timer
// What this block does
// - 16-bit mode reloads and sets high flag
// - 16-bit rollover interrupts when timer enabled
// - low byte rollover also interrupts if enabled
// - split mode: two 8-bit reloading timers
// - split mode: run bit gates only high byte
// - clock select picks system_clock, /12 or ext/8
// - ext/8 clock synchronised to system clock
// - split mode sets flag per byte rollover
// - split interrupts: high, or either if enabled
// - hardware never clears flags; software does
// - capture copies counter into reload, sets flag
// - capture on falling edge of ext/8
// - capture: 16-bit count and low byte count on system_clock or system_clock/12
`ifndef ART_MAP_SVH
`define ART_MAP_SVH

// ********************************
// register addresses on the sfr port
// ********************************
`define ART_ADDR_CTRL 8'hc8
`define ART_ADDR_RL_LO 8'hca
`define ART_ADDR_RL_HI 8'hcb
`define ART_ADDR_CNT_LO 8'hcc
`define ART_ADDR_CNT_HI 8'hcd

// ********************************
// control field positions
// ********************************
`define ART_BIT_TF_HI 7
`define ART_BIT_TF_LO 6
`define ART_BIT_LO_IEN 5
`define ART_BIT_CAP_EN 4
`define ART_BIT_SPLIT 3
`define ART_BIT_RUN 2
`define ART_BIT_RSVD 1
`define ART_BIT_XCLK 0

// ********************************
// reset values and timing counts
// ********************************
`define ART_CTRL_RST 8'h00
`define ART_CNT_RST 16'h0000
`define ART_RL_RST 16'h0000
`define ART_PSC_DIV 4'hc
`define ART_EXT_DIV 4'h8
`define ART_EXT_TICK_PH 3'h3
`define ART_EXT_CAP_PH 3'h7

`endif

/* File: core/art_pkg.sv */
// types shared by the auto-reload timer
package art_pkg;

  // one sfr access per cycle
  typedef struct packed {
    logic [7:0] addr;   // register address
    logic wr;           // write strobe, one cycle
    logic [7:0] wdata;  // write data
  } art_sfr_req_t;

  // control register fields, msb first
  typedef struct packed {
    logic tf_hi;    // high_overflow_flag
    logic tf_lo;    // low_overflow_flag
    logic lo_ien;   // low_byte_irq_enable
    logic cap_en;   // capture_mode_enable
    logic split;    // split_mode_bit
    logic run;      // run_control_bit
    logic rsvd;     // always zero
    logic xclk;     // external_clock_select
  } art_ctrl_t;

  // whole timer state
  typedef struct packed {
    art_ctrl_t ctrl;     // control register
    logic [15:0] cnt;    // count_high_byte : count_low_byte
    logic [15:0] rl;     // reload_high_byte : reload_low_byte
    logic [3:0] psc;     // system clock /12 prescaler
    logic [2:0] div;     // ext oscillator /8 divider
    logic [2:0] sync;    // osc synchroniser plus edge history
    logic [7:0] rdata;   // registered read data
  } art_state_t;

endpackage

/* File: core/art_timer.sv */
// auto-reload timer with external oscillator capture, sfr port
`timescale 1ns/1ps
`include "art_map.svh"

module art_timer (
  input wire logic clock,
  input wire logic arst_n,
  input wire art_pkg::art_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic ext_osc,
  input wire logic high_byte_clock_select,
  input wire logic low_byte_clock_select,
  input wire logic timer_irq_enable,
  output logic timer_irq
);
  import art_pkg::*;

  // ********************************
  // state and derived strobes
  // ********************************
  art_state_t s_q;      // registered state
  art_state_t s_d;      // next state
  logic osc_rise;       // rising edge of synchronised oscillator
  logic tick12;         // one pulse per 12 system clocks
  logic ext_tick;       // rising edge of ext/8
  logic cap_evt;        // falling edge of ext/8
  logic tick_lo;        // low byte (or 16-bit) advance
  logic tick_hi;        // high byte advance in split mode
  logic wr_ctrl, wr_rl_lo, wr_rl_hi, wr_cnt_lo, wr_cnt_hi;

  // only sync[1] onward is looked at; sync[0] feeds sync[1] alone
  assign osc_rise = s_q.sync[1] & ~s_q.sync[2];
  assign tick12 = (s_q.psc == 4'(`ART_PSC_DIV - 4'h1));
  // ext/8 phases come from the synchronised edge only
  assign ext_tick = osc_rise & (s_q.div == `ART_EXT_TICK_PH);
  // divider wrap is the falling edge of ext/8
  assign cap_evt = osc_rise & (s_q.div == `ART_EXT_CAP_PH);

  // per-byte source select; capture keeps the low byte (and 16-bit count) off the measured clock
  assign tick_lo = low_byte_clock_select ? 1'b1 :
                   ((s_q.ctrl.xclk & ~s_q.ctrl.cap_en) ? ext_tick : tick12);
  assign tick_hi = high_byte_clock_select ? 1'b1 : (s_q.ctrl.xclk ? ext_tick : tick12);

  assign wr_ctrl = sfr_req.wr & (sfr_req.addr == `ART_ADDR_CTRL);
  assign wr_rl_lo = sfr_req.wr & (sfr_req.addr == `ART_ADDR_RL_LO);
  assign wr_rl_hi = sfr_req.wr & (sfr_req.addr == `ART_ADDR_RL_HI);
  assign wr_cnt_lo = sfr_req.wr & (sfr_req.addr == `ART_ADDR_CNT_LO);
  assign wr_cnt_hi = sfr_req.wr & (sfr_req.addr == `ART_ADDR_CNT_HI);

  // ********************************
  // next-state logic
  // ********************************
  always_comb begin
    logic set_hi;
    logic set_lo;
    set_hi = 1'b0;
    set_lo = 1'b0;
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], ext_osc};
    // prescaler wraps at twelve
    s_d.psc = tick12 ? 4'h0 : s_q.psc + 4'h1;
    if (osc_rise) begin
      s_d.div = s_q.div + 3'h1;
    end
    // counting
    if (!s_q.ctrl.split) begin
      if (tick_lo && s_q.ctrl.run) begin
        // low byte wrap is an event of its own in 16-bit mode
        set_lo = (s_q.cnt[7:0] == 8'hff);
        if (s_q.cnt == 16'hffff) begin
          s_d.cnt = s_q.rl;
          set_hi = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end
    end else begin
      // low byte ignores the run bit
      if (tick_lo) begin
        set_lo = (s_q.cnt[7:0] == 8'hff);
        s_d.cnt[7:0] = set_lo ? s_q.rl[7:0] : s_q.cnt[7:0] + 8'h01;
      end
      if (tick_hi && s_q.ctrl.run) begin
        set_hi = (s_q.cnt[15:8] == 8'hff);
        s_d.cnt[15:8] = set_hi ? s_q.rl[15:8] : s_q.cnt[15:8] + 8'h01;
      end
    end
    // capture snapshots the count; it overrides a same-cycle reload write
    if (s_q.ctrl.cap_en && cap_evt) begin
      s_d.rl = s_q.cnt;
      set_hi = 1'b1;
    end else begin
      if (wr_rl_lo) begin
        s_d.rl[7:0] = sfr_req.wdata;
      end
      if (wr_rl_hi) begin
        s_d.rl[15:8] = sfr_req.wdata;
      end
    end
    // software writes to the counter take precedence over counting
    if (wr_cnt_lo) begin
      s_d.cnt[7:0] = sfr_req.wdata;
    end
    if (wr_cnt_hi) begin
      s_d.cnt[15:8] = sfr_req.wdata;
    end
    if (wr_ctrl) begin
      s_d.ctrl = art_ctrl_t'(sfr_req.wdata);
    end
    // reserved bit never holds a one
    s_d.ctrl.rsvd = 1'b0;
    // hardware only sets flags; set wins over a clearing write
    s_d.ctrl.tf_hi = s_d.ctrl.tf_hi | set_hi;
    s_d.ctrl.tf_lo = s_d.ctrl.tf_lo | set_lo;
    // read data, one cycle after the address
    case (sfr_req.addr)
      `ART_ADDR_CTRL: s_d.rdata = s_q.ctrl;
      `ART_ADDR_RL_LO: s_d.rdata = s_q.rl[7:0];
      `ART_ADDR_RL_HI: s_d.rdata = s_q.rl[15:8];
      `ART_ADDR_CNT_LO: s_d.rdata = s_q.cnt[7:0];
      `ART_ADDR_CNT_HI: s_d.rdata = s_q.cnt[15:8];
      default: s_d.rdata = 8'h00;
    endcase
  end

  // ********************************
  // state register
  // ********************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata = s_q.rdata;
  // level request from flags; low flag only counts when enabled
  assign timer_irq = timer_irq_enable & (s_q.ctrl.tf_hi | (s_q.ctrl.lo_ien & s_q.ctrl.tf_lo));

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic no_cnt_wr;
  assign no_cnt_wr = ~wr_cnt_lo & ~wr_cnt_hi;

  a_wrap_reload: assert property (
    !s_q.ctrl.split && s_q.ctrl.run && tick_lo && s_q.cnt == 16'hffff && no_cnt_wr
    |=> s_q.cnt == $past(s_q.rl) && s_q.ctrl.tf_hi)
    else $error("wrap did not reload");
  a_irq_hi_flag: assert property (
    s_q.ctrl.tf_hi && timer_irq_enable |-> timer_irq)
    else $error("high flag without interrupt");
  a_irq_lo_gate: assert property (
    timer_irq && !s_q.ctrl.tf_hi |-> s_q.ctrl.lo_ien && s_q.ctrl.tf_lo)
    else $error("low flag interrupt not gated");
  // low wrap flagged in 16-bit mode
  a_wide_lo_flag: assert property (
    !s_q.ctrl.split && s_q.ctrl.run && tick_lo && s_q.cnt[7:0] == 8'hff
    |=> s_q.ctrl.tf_lo)
    else $error("low wrap not flagged in 16-bit mode");

  // ********************************
  // split mode assertions
  // ********************************
  // low byte own reload
  a_split_lo_reload: assert property (
    s_q.ctrl.split && tick_lo && s_q.cnt[7:0] == 8'hff && no_cnt_wr
    |=> s_q.cnt[7:0] == $past(s_q.rl[7:0]))
    else $error("low byte did not reload");
  a_split_hi_reload: assert property (
    s_q.ctrl.split && s_q.ctrl.run && tick_hi && s_q.cnt[15:8] == 8'hff && no_cnt_wr
    |=> s_q.cnt[15:8] == $past(s_q.rl[15:8]))
    else $error("high byte did not reload");
  a_split_lo_free: assert property (
    s_q.ctrl.split && !s_q.ctrl.run && tick_lo && s_q.cnt[7:0] != 8'hff && no_cnt_wr
    |=> s_q.cnt[7:0] == $past(s_q.cnt[7:0]) + 8'h01)
    else $error("low byte stalled");
  a_split_hi_hold: assert property (
    s_q.ctrl.split && !s_q.ctrl.run && no_cnt_wr
    |=> $stable(s_q.cnt[15:8]))
    else $error("high byte moved while stopped");
  // system clock select counts every edge
  a_system_clock_select: assert property (
    s_q.ctrl.split && s_q.ctrl.run && high_byte_clock_select && s_q.cnt[15:8] != 8'hff && no_cnt_wr
    |=> s_q.cnt[15:8] == $past(s_q.cnt[15:8]) + 8'h01)
    else $error("high byte missed a system clock");
  a_split_lo_flag: assert property (
    s_q.ctrl.split && tick_lo && s_q.cnt[7:0] == 8'hff
    |=> s_q.ctrl.tf_lo)
    else $error("split low wrap not flagged");
  a_split_hi_flag: assert property (
    s_q.ctrl.split && s_q.ctrl.run && tick_hi && s_q.cnt[15:8] == 8'hff
    |=> s_q.ctrl.tf_hi)
    else $error("split high wrap not flagged");
  a_irq_split_lo: assert property (
    s_q.ctrl.split && s_q.ctrl.lo_ien && s_q.ctrl.tf_lo && timer_irq_enable |-> timer_irq)
    else $error("split low flag without interrupt");

  // ********************************
  // flag, capture and clock assertions
  // ********************************
  // low flag sticky
  a_flag_sticky: assert property (
    s_q.ctrl.tf_lo && !wr_ctrl |=> s_q.ctrl.tf_lo)
    else $error("low flag cleared by hardware");
  a_flag_hi_sticky: assert property (
    s_q.ctrl.tf_hi && !wr_ctrl |=> s_q.ctrl.tf_hi)
    else $error("high flag cleared by hardware");
  a_capture_copy: assert property (
    s_q.ctrl.cap_en && cap_evt
    |=> s_q.rl == $past(s_q.cnt) && s_q.ctrl.tf_hi)
    else $error("capture lost");
  a_cap_spacing: assert property (
    cap_evt |=> !cap_evt [*7])
    else $error("capture events too close");
  a_ext_spacing: assert property (
    ext_tick |=> !ext_tick [*7])
    else $error("ext/8 tick too close");
  // capture counts on divided system clock
  a_cap_clock: assert property (
    s_q.ctrl.cap_en && !low_byte_clock_select |-> tick_lo == tick12)
    else $error("capture counted the measured clock");
  a_rsvd_zero: assert property (!s_q.ctrl.rsvd) else $error("reserved bit set");

  // ********************************
  // main scenarios reached
  // ********************************
  c_wrap_16: cover property (!s_q.ctrl.split && tick_lo && s_q.ctrl.run && s_q.cnt == 16'hffff);
  c_split_lo: cover property (s_q.ctrl.split && tick_lo && s_q.cnt[7:0] == 8'hff);
  c_capture: cover property (s_q.ctrl.cap_en && cap_evt);
  c_split_hi: cover property (s_q.ctrl.split && s_q.ctrl.run && tick_hi && s_q.cnt[15:8] == 8'hff);
  c_lo_irq: cover property (timer_irq && !s_q.ctrl.tf_hi);
endmodule

/* File: verification/art_timer_bench.sv */
// self-checking bench for the auto-reload timer
`timescale 1ns/1ps
module art_timer_bench;
  import art_pkg::*;
  logic clock = 0, arst_n = 0, ext_osc = 0, hsel = 0, lsel = 0, ien = 0;
  art_sfr_req_t req = '0;
  logic [7:0] rdata, hv;
  logic irq, pend = 0, strobe = 0;
  logic [8:0] q[$]; // bit 8 marks an interrupt note
  int bad_count = 0, check_count = 0, half = 0, oc = 0, n;
  int seed = 32'h959c;
  always #5 clock = ~clock;
  art_timer dut (.clock(clock), .arst_n(arst_n), .sfr_req(req), .sfr_rdata(rdata), .ext_osc(ext_osc),
    .high_byte_clock_select(hsel), .low_byte_clock_select(lsel), .timer_irq_enable(ien), .timer_irq(irq));
  // ************
  // checking
  // ************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // strobes drop after the sampling edge, so back-to-back calls never reassign them
  always @(posedge clock) begin
    pend <= strobe;
    strobe <= 1'b0;
    req.wr <= 1'b0;
  end
  // the oldest note answers the result that settles one edge after its request
  always @(negedge clock) begin
    if (pend) begin
      if (q[0][8]) chk("timer_irq", {7'h00, irq}, q[0][7:0]);
      else chk("sfr_rdata", rdata, q[0][7:0]);
      void'(q.pop_front());
    end
  end
  // external oscillator, half period in clocks, frozen at zero
  always @(negedge clock) begin
    if (half != 0) begin
      oc++;
      if (oc >= half) begin
        oc = 0;
        ext_osc <= ~ext_osc;
      end
    end
  end
  // ************
  // drivers
  // ************
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge clock);
  endtask
  task automatic note(logic [8:0] e, logic [7:0] a);
    req.addr = a;
    strobe = 1'b1;
    q.push_back(e);
    @(negedge clock);
  endtask
  // bounded wait for the interrupt, lower bound checks the tick rate
  task automatic wait_irq(int lo, int hi);
    n = 0;
    while (irq !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > hi) begin
        bad_count++;
        $display("Error timer_irq expected 1 seen %b", irq);
        give_verdict();
      end
    end
    chk("irq_delay", {7'h00, n >= lo}, 8'h01);
  endtask
  // ************
  // scenarios
  // ************
  initial begin
    repeat (12) @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
    note(9'h000, 8'hc8);
    wr(8'hc8, 8'hff);
    note(9'h0fd, 8'hc8);
    wr(8'hc8, 8'h00);
    note(9'h000, 8'hc8);
    note(9'h000, 8'h00);
    // full 16-bit wrap reloads the high byte
    lsel = 1'b1;
    ien = 1'b1;
    wr(8'hca, 8'hf0);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    wait_irq(1, 20);
    note(9'h0c4, 8'hc8);
    wr(8'hc8, 8'hc0);
    note(9'h0ff, 8'hcd);
    repeat (30) @(negedge clock);
    note(9'h101, 8'h00);
    // the interrupt compare fires on this edge, so move the enable one cycle later
    @(negedge clock);
    ien = 1'b0;
    note(9'h100, 8'h00);
    // split mode with the run bit off
    hv = 8'($random(seed));
    wr(8'hc8, 8'h00);
    wr(8'hca, 8'hfe);
    wr(8'hcc, 8'hfd);
    wr(8'hcd, hv);
    wr(8'hc8, 8'h08);
    repeat (10) @(negedge clock);
    note(9'h048, 8'hc8);
    note({1'b0, hv}, 8'hcd);
    ien = 1'b1;
    note(9'h100, 8'h00);
    wr(8'hc8, 8'h68);
    note(9'h101, 8'h00);
    // split mode with both bytes on the system clock, high byte wraps fd, fe, ff, reload
    hsel = 1'b1;
    wr(8'hcb, 8'hfe);
    wr(8'hcd, 8'hfd);
    wr(8'hc8, 8'h0c);
    repeat (4) @(negedge clock);
    note(9'h0cc, 8'hc8);
    note(9'h101, 8'h00);
    // stop the high byte first so no wrap lands on the clearing write below
    wr(8'hc8, 8'h08);
    hsel = 1'b0;
    // divided system clock, then external clock over eight
    lsel = 1'b0;
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'hf4);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    wait_irq(130, 150);
    half = 2;
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'hfc);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h05);
    // four ext/8 ticks of 32 clocks each, plus synchroniser latency
    wait_irq(96, 136);
    // capture copies the running count into the reload pair
    wr(8'hc8, 8'h00);
    wr(8'hcb, 8'h00);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h5a);
    lsel = 1'b1;
    // capture in 16-bit mode on the fast clock
    wr(8'hc8, 8'h14);
    wait_irq(1, 100);
    half = 0;
    note(9'h094, 8'hc8);
    note(9'h05a, 8'hcb);
    repeat (2) @(negedge clock);
    give_verdict();
  end
endmodule
